// ### hdl/ccp_pkg.sv
// Package of constants and carrier types for the capture/compare control unit.
`default_nettype none
package ccp_pkg;
    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [11:0] OFF_CONTROL = 12'h000;
    localparam logic [11:0] OFF_DATA = 12'h004;
    localparam logic [11:0] OFF_FLAG = 12'h008;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam int FLAG_BIT = 2;
    localparam int DUTY_LSB_POS = 4;
    localparam int MODE_POS = 0;
    // ********************************************************
    // Mode field encodings and prescaler terminal counts
    // ********************************************************
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_DIV4 = 4'h6;
    localparam logic [3:0] MODE_CAP_DIV16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
    localparam logic [3:0] PRESCALE_LAST4 = 4'h3;
    localparam logic [3:0] PRESCALE_LAST16 = 4'hF;
    // ********************************************************
    // Carrier types
    // ********************************************************
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
endpackage : ccp_pkg
`default_nettype wire

// ### hdl/ccp_control_and_capture.sv
// Control register, capture, compare and duty outputs of one capture/compare/PWM unit.
//
// The APB slave port and the placing of the registers were decided locally.
`default_nettype none
module ccp_control_and_capture
    import ccp_pkg::*;
#(
    parameter bit SECOND_UNIT = 1'b0 // Unit whose trigger also starts a conversion.
)(
    input wire logic ref_clk, // System clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire apb_req_t apb_req, // APB request.
    output apb_rsp_t apb_rsp, // APB response.
    input wire logic unit_pin, // Level seen on the unit's pin.
    input wire logic [15:0] timer1_count, // Running timer1 value.
    input wire logic adc_enable, // Converter is enabled.
    output logic compare_out, // Compare output latch.
    output logic special_trigger, // One-cycle trigger that clears timer1.
    output logic adc_start, // One-cycle conversion start.
    output logic unit_irq_flag, // Unit interrupt request flag.
    output logic [9:0] pwm_duty // Ten-bit duty value.
);
    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [5:0] ctrl;
        logic [15:0] data;
        logic flag;
        logic [3:0] cnt;
        logic [2:0] sync;
        logic match;
        logic cmp_out;
        logic trig;
        logic adc;
        apb_rsp_t rsp;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic logic is_capture(input logic [3:0] m);
        is_capture = (m[3:2] == 2'b01);
    endfunction : is_capture

    function automatic logic is_compare(input logic [3:0] m);
        is_compare = (m[3:2] == 2'b10);
    endfunction : is_compare

    logic [3:0] mode;
    logic rise;
    logic fall;
    logic match_rise;
    logic cap_event;
    logic bus_access;
    logic bus_done;
    logic wr_ctrl;
    logic wr_data;
    logic wr_flag;

    assign mode = s_q.ctrl[MODE_POS +: 4];
    // Only the second and third stages feed the edge detector.
    assign rise = s_q.sync[1] & ~s_q.sync[2];
    assign fall = ~s_q.sync[1] & s_q.sync[2];
    assign match_rise = (s_q.data == timer1_count) & ~s_q.match;
    assign bus_access = apb_req.psel & apb_req.penable;
    assign bus_done = bus_access & s_q.rsp.pready;
    assign wr_ctrl = bus_done & apb_req.pwrite & (apb_req.paddr == OFF_CONTROL);
    assign wr_data = bus_done & apb_req.pwrite & (apb_req.paddr == OFF_DATA);
    assign wr_flag = bus_done & apb_req.pwrite & (apb_req.paddr == OFF_FLAG);

    // ********************************************************
    // Capture event selection
    // ********************************************************
    always_comb
    begin
        cap_event = 1'b0;
        case (mode)
            MODE_CAP_FALL:
            begin
                cap_event = fall;
            end
            MODE_CAP_RISE:
            begin
                cap_event = rise;
            end
            MODE_CAP_DIV4:
            begin
                cap_event = rise & (s_q.cnt[1:0] == PRESCALE_LAST4[1:0]);
            end
            MODE_CAP_DIV16:
            begin
                cap_event = rise & (s_q.cnt == PRESCALE_LAST16);
            end
            default:
            begin
                cap_event = 1'b0;
            end
        endcase
    end

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.trig = 1'b0;
        s_d.adc = 1'b0;
        s_d.rsp.pready = 1'b0;
        s_d.rsp.pslverr = 1'b0;
        s_d.sync = {s_q.sync[1:0], unit_pin};
        s_d.match = (s_q.data == timer1_count);
        // APB answers one cycle into the access phase.
        if (bus_access & ~s_q.rsp.pready)
        begin
            s_d.rsp.pready = 1'b1;
            s_d.rsp.prdata = 32'h0000_0000;
            if (apb_req.paddr == OFF_CONTROL)
            begin
                s_d.rsp.prdata[7:0] = {2'b00, s_q.ctrl};
            end
            else if (apb_req.paddr == OFF_DATA)
            begin
                s_d.rsp.prdata[15:0] = s_q.data;
            end
            else if (apb_req.paddr == OFF_FLAG)
            begin
                s_d.rsp.prdata[FLAG_BIT] = s_q.flag;
            end
            else
            begin
                s_d.rsp.pslverr = 1'b1;
            end
        end
        if (wr_ctrl)
        begin
            // A mode change raises no flag of its own; only real events set it.
            s_d.ctrl = apb_req.pwdata[5:0];
        end
        if (wr_data)
        begin
            s_d.data = apb_req.pwdata[15:0];
        end
        // Flag is write-one-to-clear; a hardware set below wins.
        if (wr_flag & apb_req.pwdata[FLAG_BIT])
        begin
            s_d.flag = 1'b0;
        end
        // The prescaler counts every rising edge and wraps, so a direct
        // switch between capture modes keeps the running count.
        if (!is_capture(mode))
        begin
            s_d.cnt = 4'h0;
        end
        else if (rise)
        begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
        if (cap_event)
        begin
            s_d.data = timer1_count;
            s_d.flag = 1'b1;
        end
        if (is_compare(mode) & match_rise)
        begin
            s_d.flag = 1'b1;
            if (mode == MODE_CMP_SET)
            begin
                s_d.cmp_out = 1'b1;
            end
            else if (mode == MODE_CMP_CLR)
            begin
                s_d.cmp_out = 1'b0;
            end
            else if (mode == MODE_CMP_TRIG)
            begin
                s_d.trig = 1'b1;
                s_d.adc = SECOND_UNIT & adc_enable;
            end
        end
        if (mode == MODE_OFF)
        begin
            s_d.cmp_out = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign apb_rsp = s_q.rsp;
    assign compare_out = s_q.cmp_out;
    assign special_trigger = s_q.trig;
    assign adc_start = s_q.adc;
    assign unit_irq_flag = s_q.flag;
    assign pwm_duty = {s_q.data[7:0], s_q.ctrl[DUTY_LSB_POS +: 2]};

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_captured(logic [15:0] t);
        s_q.data == t ##0 s_q.flag;
    endsequence

    sequence s_flag_clear_write;
        wr_flag ##0 apb_req.pwdata[FLAG_BIT];
    endsequence

    chk_upper_zero: assert property (
        s_q.rsp.pready & (apb_req.paddr == OFF_CONTROL) |-> s_q.rsp.prdata[7:6] == 2'b00)
        else $error("control upper bits not zero");

    chk_fall_capture: assert property (
        (mode == MODE_CAP_FALL) & fall |=> s_captured($past(timer1_count)))
        else $error("falling edge capture missed");

    chk_rise_capture: assert property (
        (mode == MODE_CAP_RISE) & rise |=> s_captured($past(timer1_count)))
        else $error("rising edge capture missed");

    chk_div4_capture: assert property (
        (mode == MODE_CAP_DIV4) & rise & (s_q.cnt[1:0] != 2'b11) & ~wr_data |=> s_q.data == $past(s_q.data))
        else $error("capture before fourth edge");

    chk_pin_sync: assert property (
        $rose(unit_pin) ##1 1'b1 ##1 (mode == MODE_CAP_RISE) |=> s_q.flag)
        else $error("capture not two cycles after pin edge");

    chk_flag_hold: assert property (
        s_q.flag & ~wr_flag |=> s_q.flag)
        else $error("flag cleared by hardware");

    // A clear with no event in the same cycle must drop the flag.
    chk_flag_clear: assert property (
        s_flag_clear_write ##0 (~cap_event & ~(is_compare(mode) & match_rise)) |=> ~s_q.flag)
        else $error("flag not cleared by software");

    chk_cnt_clear: assert property (
        !is_capture(mode) |=> s_q.cnt == 4'h0)
        else $error("prescaler not cleared");

    chk_cnt_keep: assert property (
        is_capture(mode) & ~rise |=> s_q.cnt == $past(s_q.cnt))
        else $error("prescaler count changed");

    chk_set_pin: assert property (
        (mode == MODE_CMP_SET) & match_rise |=> compare_out & s_q.flag)
        else $error("compare set missed");

    chk_special_trig: assert property (
        (mode == MODE_CMP_TRIG) & match_rise |=> special_trigger & s_q.flag ##1 ~special_trigger)
        else $error("special trigger not one pulse");

    chk_soft_irq: assert property (
        (mode == MODE_CMP_SOFT) |=> compare_out == $past(compare_out))
        else $error("pin changed in software interrupt mode");

    chk_apb_wait: assert property (
        bus_access & ~s_q.rsp.pready |=> s_q.rsp.pready)
        else $error("apb answer late");

    chk_duty_bits: assert property (
        wr_ctrl ##1 1'b1 |-> pwm_duty[1:0] == $past(apb_req.pwdata[5:4]))
        else $error("duty low bits wrong");
endmodule : ccp_control_and_capture
`default_nettype wire

// ### tb/ccp_pin_model.sv
// Model of the external event source that drives the unit's pin.
`default_nettype none
module ccp_pin_model (
    input wire logic ref_clk, // System clock.
    output logic unit_pin // Pin level.
);
    timeunit 1ns;
    timeprecision 100ps;
    initial unit_pin = 1'b0;
    // Each pulse gives one rising and one falling edge, four cycles apart.
    task automatic rise(input int n);
        repeat (n)
        begin
            unit_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            unit_pin <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask : rise
endmodule : ccp_pin_model
`default_nettype wire

// ### tb/ccp_control_and_capture_tb.sv
// Self-checking bench for the capture/compare control unit.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module ccp_control_and_capture_tb import ccp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic unit_pin;
    logic [15:0] timer1_count = 16'h0000;
    logic adc_enable = 1'b1;
    logic compare_out, special_trigger, adc_start, unit_irq_flag;
    logic [9:0] pwm_duty;
    logic [31:0] rdat, r;
    logic rerr;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 32'h82a5;
    int trig_n = 0;
    int adc_n = 0;
    // Fields: first mode, its edges, middle mode, final mode, final edges minus one.
    logic [19:0] cases [8] = '{20'h40440, 20'h50550, 20'h60663, 20'h7077F, 20'h6277D, 20'h63063, 20'h63863, 20'h63163};
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        trig_n += int'(special_trigger === 1'b1);
        adc_n += int'(adc_start === 1'b1);
    end
    ccp_control_and_capture #(.SECOND_UNIT(1'b1)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .apb_req(req),
        .apb_rsp(rsp), .unit_pin(unit_pin), .timer1_count(timer1_count), .adc_enable(adc_enable),
        .compare_out(compare_out), .special_trigger(special_trigger), .adc_start(adc_start),
        .unit_irq_flag(unit_irq_flag), .pwm_duty(pwm_duty));
    ccp_pin_model pin (.ref_clk(ref_clk), .unit_pin(unit_pin));
    function automatic logic [9:0] exp_duty(input logic [31:0] d, input logic [1:0] lo);
        return {d[7:0], lo};
    endfunction : exp_duty
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (rsp.pready !== 1'b1);
        rdat = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", e, rdat)
    endtask : rd
    task automatic cap(input logic [19:0] c);
        logic [15:0] b;
        apb(1'b1, OFF_CONTROL, 32'h0);
        apb(1'b1, OFF_CONTROL, {28'h0, c[19:16]});
        timer1_count <= 16'($random(seed));
        pin.rise(c[15:12]);
        apb(1'b1, OFF_CONTROL, {28'h0, c[11:8]});
        apb(1'b1, OFF_CONTROL, {28'h0, c[7:4]});
        apb(1'b1, OFF_FLAG, 32'h4);
        pin.rise(c[3:0]);
        `CHK("early_flag", 1'b0, unit_irq_flag)
        b = 16'($random(seed));
        timer1_count <= b;
        pin.rise(1);
        `CHK("cap_flag", 1'b1, unit_irq_flag)
        rd(OFF_DATA, {16'h0, b});
    endtask : cap
    task automatic cmp(input logic [3:0] m, input logic o, input int t);
        logic [15:0] v;
        int t0, a0;
        v = 16'($random(seed));
        t0 = trig_n;
        a0 = adc_n;
        timer1_count <= v + 16'h1;
        apb(1'b1, OFF_DATA, {16'h0, v});
        apb(1'b1, OFF_CONTROL, {28'h0, m});
        apb(1'b1, OFF_FLAG, 32'h4);
        timer1_count <= v;
        repeat (3) @(posedge ref_clk);
        timer1_count <= v + 16'h2;
        repeat (2) @(posedge ref_clk);
        `CHK("cmp_flag", 1'b1, unit_irq_flag)
        `CHK("cmp_pin", o, compare_out)
        `CHK("trigger", t, trig_n - t0)
        `CHK("adc", adc_enable ? t : 0, adc_n - a0)
    endtask : cmp
    task automatic final_report();
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rd(OFF_CONTROL, 32'h0);
        rd(OFF_DATA, 32'h0);
        rd(OFF_FLAG, 32'h0);
        r = $random(seed);
        apb(1'b1, OFF_DATA, r);
        apb(1'b1, OFF_CONTROL, {24'h0, 2'b11, r[5:4], 4'hC});
        rd(OFF_CONTROL, {26'h0, r[5:4], 4'hC});
        `CHK("duty", exp_duty(r, r[5:4]), pwm_duty)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK("slverr", 1'b1, rerr)
        foreach (cases[i]) cap(cases[i]);
        apb(1'b1, OFF_CONTROL, {28'h0, MODE_CAP_RISE});
        r = $random(seed);
        timer1_count <= r[31:16];
        pin.rise(1);
        timer1_count <= r[15:0];
        pin.rise(1);
        repeat (40) @(posedge ref_clk);
        rd(OFF_DATA, {16'h0, r[15:0]});
        rd(OFF_FLAG, 32'h4);
        apb(1'b1, OFF_CONTROL, 32'h0);
        apb(1'b1, OFF_FLAG, 32'h4);
        pin.rise(2);
        `CHK("off_flag", 1'b0, unit_irq_flag)
        `CHK("off_pin", 1'b0, compare_out)
        cmp(MODE_CMP_SET, 1'b1, 0);
        cmp(MODE_CMP_SOFT, 1'b1, 0);
        cmp(MODE_CMP_CLR, 1'b0, 0);
        cmp(MODE_CMP_TRIG, 1'b0, 1);
        adc_enable <= 1'b0;
        cmp(MODE_CMP_TRIG, 1'b0, 1);
        final_report();
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end
endmodule : ccp_control_and_capture_tb
`default_nettype wire
